// File: verilog/cmav_core.sv
// cmav_core: operating mode, address generation, vectors, indirect branch,
// stack pushes and execution timing of the cpu core
// assumes memory answers each bus request with a one-cycle bus_ack
//
// How it works
// - register add or subtract of 8, 16 or 32 bits finishes in one state.
// - 16 by 8 bit register divide takes twelve states.
// - 16 by 16 bit register multiply takes twenty states.
// - 32 by 16 bit register divide takes twenty states.
// - mode pins pick the mode; small reaches 64 kbytes, large 16 Mbytes.
// - only the large linear mode is offered on this part.
// - small mode keeps only the lower 16 bits of each effective address except the fetch address, which keeps 24.
// - small mode vectors start at zero, one 16-bit branch address each.
// - small mode indirect jump reads a 16-bit target from 0 to 0xFF.
// - large mode vectors are 32-bit; top byte dropped, low 24 bits used.
// - large mode indirect jump reads a longword, top byte taken as zero.
// - small mode increment or decrement carries into the extended half.
// - large mode extended halves also form upper halves of long registers.
// - a subroutine call pushes the program counter.
// - exceptions push pc, ccr and extended control, the latter not in mode 0.
// - large mode gives linear 16-Mbyte access of a 4-Gbyte architecture.
// - the sleep instruction puts the core into power-down.
// - instruction fetch forces the program counter's low bit to zero.
`timescale 1ns/10ps
module cmav_core
    import cmav_pkg::*;
#(
    parameter logic SMALL_MODE_AVAIL = 1'b0
) (
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      arst_n,
    // mode pins and wake
    input  wire logic      mode_pin_large,
    input  wire logic      wake,
    // request side
    input  wire logic      req_valid,
    input  wire cmav_req_t req,
    output logic           req_ready,
    output logic           done,
    output cmav_rsp_t      rsp,
    // memory bus side
    output cmav_bus_t      bus,
    input  wire logic      bus_ack,
    input  wire logic [31:0] bus_rdata,
    // status
    output logic           pwr_down,
    output logic           large_mode
);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_EXEC  = 3'b001,
        ST_BUS   = 3'b011,
        ST_SLEEP = 3'b010
    } cmav_state_t;

    // width of address masking by mode
    function automatic logic [23:0] ea_mask(input logic [31:0] a, input logic lg);
        ea_mask = lg ? a[23:0] : {8'h00, a[15:0]};
    endfunction : ea_mask

    function automatic logic [31:0] sz_bytes(input cmav_size_t s);
        unique case (s)
            SZ_BYTE: sz_bytes = 32'h0000_0001;
            SZ_WORD: sz_bytes = 32'h0000_0002;
            default: sz_bytes = 32'h0000_0004;
        endcase
    endfunction : sz_bytes

    function automatic logic [4:0] exec_cycles(input cmav_cmd_t c);
        unique case (c)
            CMD_DIV16: exec_cycles = DIV16_CYC;
            CMD_MUL16: exec_cycles = MUL16_CYC;
            CMD_DIV32: exec_cycles = DIV32_CYC;
            default:   exec_cycles = ADDSUB_CYC;
        endcase
    endfunction : exec_cycles

    // arithmetic and register update results
    function automatic logic [31:0] alu(input cmav_req_t r);
        logic [31:0] sum;
        logic [15:0] q16;
        logic [15:0] r16;
        logic [31:0] q32;
        logic [31:0] r32;
        sum = (r.cmd == CMD_SUB) ? r.a - r.b : r.a + r.b;
        q16 = (r.b[7:0] == 8'h00) ? 16'hFFFF : r.a[15:0] / {8'h00, r.b[7:0]};
        r16 = (r.b[7:0] == 8'h00) ? r.a[15:0] : r.a[15:0] % {8'h00, r.b[7:0]};
        q32 = (r.b[15:0] == 16'h0000) ? 32'hFFFF_FFFF : r.a / {16'h0000, r.b[15:0]};
        r32 = (r.b[15:0] == 16'h0000) ? r.a : r.a % {16'h0000, r.b[15:0]};
        unique case (r.cmd)
            CMD_ADD, CMD_SUB: begin
                unique case (r.size)
                    SZ_BYTE: alu = {24'h000000, sum[7:0]};
                    SZ_WORD: alu = {16'h0000, sum[15:0]};
                    default: alu = sum;
                endcase
            end
            CMD_DIV16:   alu = {16'h0000, r16[7:0], q16[7:0]};
            CMD_MUL16:   alu = r.a[15:0] * r.b[15:0];
            CMD_DIV32:   alu = {r32[15:0], q32[15:0]};
            CMD_EA:      alu = r.a + r.b;
            // full 32-bit update: carry/borrow reaches the extended half
            CMD_POSTINC: alu = r.a + sz_bytes(r.size);
            CMD_PREDEC:  alu = r.a - sz_bytes(r.size);
            default:     alu = 32'h0000_0000;
        endcase
    endfunction : alu

    // reset release synchroniser
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    cmav_state_t state_q, state_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [1:0]  step_q, step_d;
    cmav_req_t   cur_q, cur_d;
    logic [31:0] sp_q, sp_d;
    cmav_rsp_t   rsp_q, rsp_d;
    cmav_bus_t   bus_q, bus_d;
    logic        done_q, done_d;
    logic        ready_q, ready_d;
    logic        pd_q, pd_d;
    logic        large_q, large_d;
    logic        strap_q, strap_d;
    logic        acc;
    logic [31:0] sp_nx;

    assign acc = req_valid && ready_q;

    // mode strap, caught once after reset release
    always_comb begin
        strap_d = 1'b1;
        large_d = large_q;
        if (!strap_q) begin
            large_d = SMALL_MODE_AVAIL ? mode_pin_large : 1'b1;
        end
    end

    // sequencer next values
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        step_d  = step_q;
        cur_d   = cur_q;
        sp_d    = sp_q;
        rsp_d   = rsp_q;
        bus_d   = bus_q;
        done_d  = 1'b0;
        pd_d    = pd_q;
        sp_nx   = sp_q;
        unique case (state_q)
            ST_IDLE: begin
                if (acc) begin
                    cur_d  = req;
                    step_d = STEP_EXR;
                    sp_d   = req.a;
                    unique case (req.cmd)
                        CMD_FETCH: begin
                            bus_d   = '{req: 1'b1, we: 1'b0, size: SZ_WORD,
                                        addr: {req.a[23:1], 1'b0},
                                        wdata: 32'h0000_0000};
                            state_d = ST_BUS;
                        end
                        CMD_VECTOR: begin
                            bus_d.req   = 1'b1;
                            bus_d.we    = 1'b0;
                            bus_d.wdata = 32'h0000_0000;
                            bus_d.size  = large_q ? SZ_LONG : SZ_WORD;
                            bus_d.addr  = large_q
                                ? VEC_BASE + ({16'h0000, req.sel} << VEC_SHIFT_LARGE)
                                : VEC_BASE + ({16'h0000, req.sel} << VEC_SHIFT_SMALL);
                            state_d     = ST_BUS;
                        end
                        CMD_MEMIND: begin
                            // target operand lies in 0x00..0xFF
                            bus_d   = '{req: 1'b1, we: 1'b0,
                                        size: large_q ? SZ_LONG : SZ_WORD,
                                        addr: {16'h0000, req.sel},
                                        wdata: 32'h0000_0000};
                            state_d = ST_BUS;
                        end
                        CMD_CALL: begin
                            sp_nx   = req.a - (large_q ? 32'h4 : 32'h2);
                            sp_d    = sp_nx;
                            bus_d   = '{req: 1'b1, we: 1'b1,
                                        size: large_q ? SZ_LONG : SZ_WORD,
                                        addr: ea_mask(sp_nx, large_q),
                                        wdata: large_q ? {8'h00, req.b[23:0]}
                                                       : {16'h0000, req.b[15:0]}};
                            state_d = ST_BUS;
                        end
                        CMD_EXCEPT: begin
                            // extended control skipped in interrupt mode 0
                            if (req.icm0) begin
                                step_d = STEP_CCR;
                                sp_nx  = req.a - (large_q ? 32'h4 : 32'h2);
                                bus_d  = '{req: 1'b1, we: 1'b1,
                                           size: large_q ? SZ_LONG : SZ_WORD,
                                           addr: ea_mask(sp_nx, large_q),
                                           wdata: large_q ? {req.condition_code_reg, req.b[23:0]}
                                                          : {16'h0000, req.condition_code_reg, req.condition_code_reg}};
                            end else begin
                                sp_nx = req.a - 32'h2;
                                bus_d = '{req: 1'b1, we: 1'b1, size: SZ_WORD,
                                          addr: ea_mask(sp_nx, large_q),
                                          wdata: {16'h0000, req.extended_control_reg, req.extended_control_reg}};
                            end
                            sp_d    = sp_nx;
                            state_d = ST_BUS;
                        end
                        CMD_SLEEP: begin
                            pd_d    = 1'b1;
                            state_d = ST_SLEEP;
                        end
                        default: begin
                            rsp_d.data = alu(req);
                            unique case (req.cmd)
                                CMD_POSTINC: rsp_d.addr = ea_mask(req.a, large_q);
                                CMD_PREDEC:  rsp_d.addr = ea_mask(rsp_d.data, large_q);
                                CMD_EA:      rsp_d.addr = ea_mask(rsp_d.data, large_q);
                                default:     rsp_d.addr = 24'h000000;
                            endcase
                            cnt_d   = exec_cycles(req.cmd) - 5'h01;
                            state_d = ST_EXEC;
                        end
                    endcase
                end
            end
            ST_EXEC: begin
                if (cnt_q == 5'h00) begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            ST_BUS: begin
                if (bus_ack) begin
                    bus_d.req = 1'b0;
                    done_d    = 1'b1;
                    state_d   = ST_IDLE;
                    unique case (cur_q.cmd)
                        CMD_FETCH: rsp_d = '{data: bus_rdata, addr: bus_q.addr};
                        CMD_VECTOR, CMD_MEMIND: begin
                            // top byte of a long entry is ignored
                            rsp_d.addr = ea_mask(bus_rdata, large_q);
                            rsp_d.data = {8'h00, rsp_d.addr};
                        end
                        CMD_EXCEPT: begin
                            rsp_d = '{data: sp_q, addr: ea_mask(sp_q, large_q)};
                            if (!(step_q == STEP_PC || (large_q && step_q == STEP_CCR))) begin
                                done_d  = 1'b0;
                                state_d = ST_BUS;
                                step_d  = step_q + 2'h1;
                                if (large_q || step_q == STEP_EXR) begin
                                    sp_nx = sp_q - (large_q ? 32'h4 : 32'h2);
                                    bus_d = '{req: 1'b1, we: 1'b1,
                                              size: large_q ? SZ_LONG : SZ_WORD,
                                              addr: ea_mask(sp_nx, large_q),
                                              wdata: large_q ? {cur_q.condition_code_reg, cur_q.b[23:0]}
                                                             : {16'h0000, cur_q.condition_code_reg,
                                                                cur_q.condition_code_reg}};
                                end else begin
                                    sp_nx = sp_q - 32'h2;
                                    bus_d = '{req: 1'b1, we: 1'b1, size: SZ_WORD,
                                              addr: ea_mask(sp_nx, large_q),
                                              wdata: {16'h0000, cur_q.b[15:0]}};
                                end
                                sp_d = sp_nx;
                            end
                        end
                        default: rsp_d = '{data: sp_q, addr: ea_mask(sp_q, large_q)};
                    endcase
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    pd_d    = 1'b0;
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        ready_d = (state_d == ST_IDLE);
    end

    // sequencer and mode registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
            step_q  <= STEP_EXR;
            cur_q   <= '0;
            sp_q    <= SP_RESET;
            rsp_q   <= '0;
            bus_q   <= '0;
            done_q  <= 1'b0;
            ready_q <= 1'b0;
            pd_q    <= 1'b0;
            large_q <= LARGE_RST;
            strap_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            step_q  <= step_d;
            cur_q   <= cur_d;
            sp_q    <= sp_d;
            rsp_q   <= rsp_d;
            bus_q   <= bus_d;
            done_q  <= done_d;
            ready_q <= ready_d;
            pd_q    <= pd_d;
            large_q <= large_d;
            strap_q <= strap_d;
        end
    end

    assign req_ready  = ready_q;
    assign done       = done_q;
    assign rsp        = rsp_q;
    assign bus        = bus_q;
    assign pwr_down   = pd_q;
    assign large_mode = large_q;

    sequence s_quiet8;
        (!done_q) [*8];
    endsequence

    // done_q rises at the n-th edge after the take edge, seen one edge later
    AST_ADDSUB_ONE: assert property ((acc && (req.cmd == CMD_ADD || req.cmd == CMD_SUB))
        |=> !done_q ##1 done_q) else $error("add/sub not done in one state");
    AST_DIV16_TWELVE: assert property ((acc && req.cmd == CMD_DIV16)
        |=> s_quiet8 ##1 (!done_q) [*4] ##1 done_q) else $error("div16 not twelve states");
    AST_MUL16_TWENTY: assert property ((acc && req.cmd == CMD_MUL16)
        |=> s_quiet8 ##1 s_quiet8 ##1 (!done_q) [*4] ##1 done_q)
        else $error("mul16 not twenty states");
    AST_DIV32_TWENTY: assert property ((acc && req.cmd == CMD_DIV32)
        |=> s_quiet8 ##1 s_quiet8 ##1 (!done_q) [*4] ##1 done_q)
        else $error("div32 not twenty states");
    AST_LARGE_ONLY: assert property (strap_q && !SMALL_MODE_AVAIL |-> large_q)
        else $error("small mode reached");
    AST_FETCH_EVEN: assert property (bus_q.req && cur_q.cmd == CMD_FETCH
        |-> !bus_q.addr[0] && bus_q.addr[23:1] == cur_q.a[23:1]) else $error("fetch odd");
    AST_VECTOR_LONG: assert property (bus_q.req && large_q && cur_q.cmd == CMD_VECTOR
        |-> bus_q.size == SZ_LONG && bus_q.addr == {14'h0000, cur_q.sel, 2'b00})
        else $error("vector address wrong");
    AST_INDIRECT_TOP: assert property (bus_ack && bus_q.req && large_q
        && cur_q.cmd == CMD_MEMIND |=> done_q && rsp_q.data == {8'h00, $past(bus_rdata[23:0])})
        else $error("indirect target top byte");
    AST_CALL_PUSH: assert property ((acc && large_q && req.cmd == CMD_CALL)
        |=> bus_q.req && bus_q.we && bus_q.addr == $past(req.a[23:0]) - 24'h4)
        else $error("call push wrong");
    AST_EXR_SKIP: assert property ((acc && large_q && req.cmd == CMD_EXCEPT && req.icm0)
        |=> bus_q.size == SZ_LONG ##1 (bus_q.req) [*1]) else $error("exr pushed in mode 0");
    AST_SLEEP_PD: assert property ((acc && req.cmd == CMD_SLEEP)
        |=> pd_q && !ready_q) else $error("sleep not taken");
    AST_SMALL_EA: assert property (done_q && !large_q |-> rsp_q.addr[23:16] == 8'h00)
        else $error("small ea too wide");

endmodule : cmav_core

// File: verilog/cmav_pkg.sv
// cmav_pkg: constants, commands and carriers for the mode/address core block
// assumes one 250 MHz clock domain; memory sits behind a simple req/ack bus
package cmav_pkg;

    // address and data widths
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 32;

    // execution lengths in states (one state = one core_clk cycle)
    localparam logic [4:0] ADDSUB_CYC = 5'h01;
    localparam logic [4:0] DIV16_CYC  = 5'h0C;
    localparam logic [4:0] MUL16_CYC  = 5'h14;
    localparam logic [4:0] DIV32_CYC  = 5'h14;

    // exception vector table base and entry shifts
    localparam logic [23:0] VEC_BASE        = 24'h000000;
    localparam int unsigned VEC_SHIFT_SMALL = 1;
    localparam int unsigned VEC_SHIFT_LARGE = 2;

    // values after reset
    localparam logic [31:0] SP_RESET   = 32'h0000_0000;
    localparam logic        LARGE_RST  = 1'b1;

    // exception push steps
    localparam logic [1:0] STEP_EXR  = 2'h0;
    localparam logic [1:0] STEP_CCR  = 2'h1;
    localparam logic [1:0] STEP_PC   = 2'h2;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ADD, CMD_SUB, CMD_DIV16, CMD_MUL16, CMD_DIV32,
        CMD_EA, CMD_POSTINC, CMD_PREDEC, CMD_FETCH, CMD_VECTOR,
        CMD_MEMIND, CMD_CALL, CMD_EXCEPT, CMD_SLEEP
    } cmav_cmd_t;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cmav_size_t;

    typedef struct packed {
        cmav_cmd_t   cmd;
        cmav_size_t  size;
        logic [31:0] a;
        logic [31:0] b;
        logic [7:0]  sel;
        logic [7:0]  condition_code_reg;
        logic [7:0]  extended_control_reg;
        logic        icm0;
    } cmav_req_t;

    typedef struct packed {
        logic        req;
        logic        we;
        cmav_size_t  size;
        logic [23:0] addr;
        logic [31:0] wdata;
    } cmav_bus_t;

    typedef struct packed {
        logic [31:0] data;
        logic [23:0] addr;
    } cmav_rsp_t;

endpackage : cmav_pkg

// File: dv/cmav_mem_model.sv
// cmav_mem_model: behavioural memory behind the core's bus
// assumes one access at a time, req held until this model acks it
`timescale 1ns/10ps
module cmav_mem_model
    import cmav_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // bus from the core
    input  wire cmav_bus_t   bus,
    output logic             bus_ack,
    output logic [31:0]      bus_rdata
);
    int unsigned wait_q;

    // contents as a function of address; top byte non-zero except where a[7:0] is 0xC3
    function automatic logic [31:0] mem_word(input logic [23:0] a);
        return {8'hC3 ^ a[7:0], a ^ 24'h5A5A5A};
    endfunction : mem_word

    // answer after 0..3 idle cycles; data toggles while not valid
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_ack   <= 1'b0;
            bus_rdata <= 32'hFFFF_FFFF;
            wait_q    <= 0;
        end else if (bus.req && !bus_ack && wait_q == 0) begin
            bus_ack   <= 1'b1;
            bus_rdata <= bus.we ? ~bus_rdata : mem_word(bus.addr);
            wait_q    <= $urandom_range(0, 3);
        end else begin
            bus_ack   <= 1'b0;
            bus_rdata <= ~bus_rdata;
            if (bus.req && !bus_ack) wait_q <= wait_q - 1;
        end
    end
endmodule : cmav_mem_model

// File: dv/cmav_core_bench.sv
// cmav_core_bench: self-checking bench for the mode/address core block
// assumes cmav_mem_model on the bus; one 250 MHz clock
`timescale 1ns/10ps
module cmav_core_bench
    import cmav_pkg::*;
;
    logic        core_clk, arst_n, mode_pin_large, wake, req_valid, req_ready;
    logic        done, bus_ack, pwr_down, large_mode, icm_v;
    logic [31:0] bus_rdata, ra, rb, w;
    logic [23:0] sp, ad;
    logic [7:0]  ccr_v, exr_v, sel;
    logic [56:0] acc_q[$];
    cmav_req_t   req;
    cmav_rsp_t   rsp;
    cmav_bus_t   bus;
    int          n_mismatch, num_checks, cyc, lat;

    // clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    cmav_core #(.SMALL_MODE_AVAIL(1'b0)) uut (
        .core_clk(core_clk), .arst_n(arst_n), .mode_pin_large(mode_pin_large),
        .wake(wake), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .rsp(rsp), .bus(bus), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .pwr_down(pwr_down), .large_mode(large_mode));

    cmav_mem_model mem (.core_clk(core_clk), .arst_n(arst_n), .bus(bus),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata));

    // log each completed access as {we, addr, data}; cut a hang short
    always @(posedge core_clk) begin
        if (arst_n && bus.req && bus_ack)
            acc_q.push_back({bus.we, bus.addr, bus.we ? bus.wdata : bus_rdata});
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [31:0] exp_word(input logic [23:0] a);
        return {8'hC3 ^ a[7:0], a ^ 24'h5A5A5A};
    endfunction : exp_word

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_lat(input int got, input int exp);
        num_checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t lat got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_lat

    // pop one logged access and compare it
    task automatic chk_acc(input logic we, input logic [23:0] a, input logic [31:0] d,
                           input logic dk);
        logic [56:0] e;
        e = (acc_q.size() != 0) ? acc_q.pop_front() : 57'h0;
        chk_val({31'h0, e[56]}, {31'h0, we});
        chk_val({8'h0, e[55:32]}, {8'h0, a});
        if (dk) chk_val(e[31:0], d);
    endtask : chk_acc

    // offer one request from a falling edge, wait for done, count latency
    task automatic run(input cmav_cmd_t c, input cmav_size_t s, input logic [31:0] a,
                       input logic [31:0] b);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        req       = '{cmd: c, size: s, a: a, b: b, sel: sel, condition_code_reg: ccr_v, extended_control_reg: exr_v,
                      icm0: icm_v};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        lat       = 0;
        while (done !== 1'b1 && lat < 100) begin
            @(negedge core_clk);
            lat++;
        end
    endtask : run

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        n_mismatch = 0;
        num_checks = 0;
        cyc = 0;
        arst_n = 1'b0;
        mode_pin_large = 1'b0;
        wake = 1'b0;
        req_valid = 1'b0;
        req = '0;
        {ccr_v, exr_v, icm_v, sel} = '0;
        void'($urandom(32'h86d5b95d));
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_val({31'h0, large_mode}, 32'h1);
        $display("test mode done");
        // add, subtract and step through every size, back to back
        for (int i = 0; i < 12; i++) begin
            ra = $urandom();
            rb = $urandom();
            w = (i % 3 == 0) ? 32'hFF : (i % 3 == 1) ? 32'hFFFF : 32'hFFFF_FFFF;
            run(i < 6 ? ((i & 1) ? CMD_SUB : CMD_ADD) : ((i & 1) ? CMD_PREDEC : CMD_POSTINC),
                cmav_size_t'(i % 3), ra, rb);
            chk_lat(lat, 1);
            if (i < 6) chk_val(rsp.data, ((i & 1) ? ra - rb : ra + rb) & w);
            else begin
                w = (i & 1) ? ra - (1 << (i % 3)) : ra + (1 << (i % 3));
                chk_val(rsp.data, w);
                chk_val({8'h0, rsp.addr}, ((i & 1) ? w : ra) & 32'hFF_FFFF);
            end
        end
        $display("test arith done");
        // divide and multiply timing and results
        for (int i = 0; i < 4; i++) begin
            rb = $urandom_range(1, 255);
            ra = $urandom_range(0, rb * 256 - 1);
            run(CMD_DIV16, SZ_WORD, ra, rb);
            chk_lat(lat, 12);
            chk_val(rsp.data, {16'h0, 8'(ra % rb), 8'(ra / rb)});
            ra = $urandom_range(0, 32'hFFFF);
            rb = $urandom_range(0, 32'hFFFF);
            run(CMD_MUL16, SZ_WORD, ra, rb);
            chk_lat(lat, 20);
            chk_val(rsp.data, ra * rb);
            rb = $urandom_range(1, 32'hFFFF);
            ra = {16'($urandom_range(0, rb - 1)), 16'($urandom())};
            run(CMD_DIV32, SZ_LONG, ra, rb);
            chk_lat(lat, 20);
            chk_val(rsp.data, {16'(ra % rb), 16'(ra / rb)});
        end
        $display("test muldiv done");
        // fetch, vector and indirect branch reads
        for (int i = 0; i < 4; i++) begin
            ra = $urandom();
            run(CMD_FETCH, SZ_WORD, ra, 32'h0);
            ad = {ra[23:1], 1'b0};
            chk_acc(1'b0, ad, 32'h0, 1'b0);
            chk_val(rsp.data, exp_word(ad));
            sel = 8'($urandom());
            run(CMD_VECTOR, SZ_LONG, 32'h0, 32'h0);
            ad = {14'h0, sel, 2'b00};
            w = exp_word(ad);
            chk_acc(1'b0, ad, 32'h0, 1'b0);
            chk_val({8'h0, rsp.addr}, {8'h0, w[23:0]});
            chk_val(rsp.data, {8'h0, w[23:0]});
            sel = sel & 8'hFC;
            run(CMD_MEMIND, SZ_LONG, 32'h0, 32'h0);
            ad = {16'h0, sel};
            w = exp_word(ad);
            chk_acc(1'b0, ad, 32'h0, 1'b0);
            chk_val({8'h0, rsp.addr}, {8'h0, w[23:0]});
        end
        $display("test reads done");
        // stack pushes of call and exception entry, with and without mode 0
        for (int i = 0; i < 4; i++) begin
            sp = {20'($urandom_range(1, 32'hFFFFF)), 4'h0};
            rb = {8'h0, 23'($urandom()), 1'b0};
            {ccr_v, exr_v} = 16'($urandom());
            icm_v = i[0];
            run(i < 2 ? CMD_CALL : CMD_EXCEPT, SZ_LONG, {8'h0, sp}, rb);
            if (i < 2) begin
                chk_acc(1'b1, sp - 24'h4, {8'h0, rb[23:0]}, 1'b1);
                chk_val(rsp.data, {8'h0, sp - 24'h4});
            end else begin
                if (!icm_v) chk_acc(1'b1, sp - 24'h2, {16'h0, exr_v, exr_v}, 1'b1);
                ad = icm_v ? sp - 24'h4 : sp - 24'h6;
                chk_acc(1'b1, ad, {ccr_v, rb[23:0]}, 1'b1);
                chk_val(rsp.data, {8'h0, ad});
            end
            chk_val(acc_q.size(), 32'h0);
        end
        $display("test stack done");
        // sleep holds power-down until wake
        run(CMD_NOP, SZ_BYTE, 32'h0, 32'h0);
        req       = '{cmd: CMD_SLEEP, size: SZ_BYTE, default: '0};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        chk_val({30'h0, pwr_down, req_ready}, 32'h2);
        wake = 1'b1;
        @(negedge core_clk);
        wake = 1'b0;
        chk_val({30'h0, pwr_down, done}, 32'h1);
        $display("test sleep done");
        end_sim();
    end
endmodule : cmav_core_bench
